// ==== sdd_pkg.sv ====
// Functional notes
// R1 - Output stage enabled while enable input high or open, disabled when low.
// R2 - Position counter keeps moving on steps even while output stage is disabled.
// R3 - Clock type defaults to step plus direction until another type is chosen.
// R4 - Step/direction mode: each rising step edge moves one microstep, sign from direction.
// R5 - Position change per accepted step scales with the latched resolution; quadrature and up/down modes use the live res_weight instead.
// R6 - A setting chooses which rotation sense each direction level means.
// R7 - Quadrature uses step as phase A, direction as B; up/down uses step as up.
// R8 - Up/down mode: direction input is a separate count-down clock.
// R9 - Rising step edge captures direction and resolution; the step uses those captures.
// R10 - Direction or resolution changes act only at the next rising step edge; in quadrature and up/down modes a res_weight change acts at once.
// R11 - Run and hold current settings apply immediately, independent of steps.
// R12 - Both clock inputs pass a programmable filter from 50 ns to 12.9 us; the code clamps it to 2 to 322 sample periods (80 ns to 12.88 us).
// R13 - Controller drives step and direction; enable may be left open.
// R14 - Serial master makes the serial clock, one cycle per transferred bit.
// R15 - Each drive has its own chip select; master selects one at a time.
// R16 - Only the selected drive drives the master-in line; others leave it undriven.
// R17 - Quadrature: every single-channel edge moves one microstep; double transitions ignored.
// R18 - Filter passes a new level only after it stays stable for the set time.
package sdd_pkg;

  localparam int unsigned MCLK_PERIOD_NS = 40;
  localparam int unsigned FILT_MIN_NS    = 50;
  localparam int unsigned FILT_MAX_NS    = 12900;
  localparam logic [8:0]  FILT_MIN_CYC   = 9'((FILT_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [8:0]  FILT_MAX_CYC   = 9'(FILT_MAX_NS / MCLK_PERIOD_NS);

  localparam logic [31:0] POS_RST        = 32'h0000_0000;
  localparam logic [8:0]  RES_RST        = 9'h001;
  localparam logic [6:0]  CUR_RST        = 7'h00;
  localparam logic [4:0]  SPI_LAST_BIT   = 5'h1f;
  localparam logic [31:0] WORD_RST       = 32'h0000_0000;

  // Code 2'h2 is not assigned and decodes as step/direction
  typedef enum logic [1:0] {
    SDD_CLK_STEP_DIR = 2'h0,
    SDD_CLK_QUAD     = 2'h1,
    SDD_CLK_UP_DOWN  = 2'h3
  } sdd_clk_type_t;

  typedef struct packed {
    logic [2:0]      sync1;
    logic [2:0]      sync2;
    logic [1:0]      filt;
    logic [1:0]      filt_prev;
    logic [1:0][8:0] fcnt;
    logic            stage_en;
    logic [31:0]     pos;
    logic            moved;
    logic            dir_lat;
    logic [8:0]      res_lat;
    logic [6:0]      run_cur;
    logic [6:0]      hold_cur;
    logic            cs_s1;
    logic            cs_s2;
    logic            tgl_s1;
    logic            tgl_s2;
    logic            tgl_prev;
    logic [31:0]     cfg;
    logic            cfg_vld;
    logic            miso_oe;
    logic [31:0]     snap;
  } sdd_core_t;

  typedef struct packed {
    logic [4:0]  cnt;
    logic [30:0] shift;
    logic        miso;
  } sdd_frame_t;

  typedef struct packed {
    logic [31:0] rx;
    logic        tgl;
  } sdd_keep_t;

endpackage

// ==== sdd_step_dir_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdd_step_dir_decoder (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        step_i,
  input  wire logic        dir_i,
  input  wire logic        en_i,
  input  wire logic [1:0]  clk_type,
  input  wire logic        dir_invert,
  input  wire logic [8:0]  res_weight,
  input  wire logic [8:0]  clock_input_filter_setting,
  input  wire logic [6:0]  run_current,
  input  wire logic [6:0]  hold_current,
  input  wire logic        spi_clk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             stage_enable,
  output logic [31:0]      position,
  output logic             step_moved,
  output logic             dir_latched,
  output logic [8:0]       res_latched,
  output logic [6:0]       run_current_out,
  output logic [6:0]       hold_current_out,
  output logic [31:0]      cfg_word,
  output logic             cfg_word_valid,
  output logic             spi_miso_o,
  output logic             spi_miso_oe
);

  sdd_pkg::sdd_core_t  st_ff;
  sdd_pkg::sdd_core_t  nxt_st;
  sdd_pkg::sdd_frame_t fr_ff;
  sdd_pkg::sdd_frame_t nxt_fr;
  sdd_pkg::sdd_keep_t  kp_ff;
  sdd_pkg::sdd_keep_t  nxt_kp;
  logic                frame_rst_n;

  logic [8:0]          need;
  logic                quad_phase_a;
  logic                quad_phase_b;
  logic                a_chg;
  logic                b_chg;
  logic                step_rise;
  logic                dir_rise;
  logic                mv_up;
  logic                mv_dn;
  logic                sense;
  logic [31:0]         wt;
  sdd_pkg::sdd_clk_type_t ctype;

  // Sample clock domain
  always_comb begin
    nxt_st = st_ff;
    need = 9'h000;
    quad_phase_a = 1'b0;
    quad_phase_b = 1'b0;
    a_chg = 1'b0;
    b_chg = 1'b0;
    step_rise = 1'b0;
    dir_rise = 1'b0;
    mv_up = 1'b0;
    mv_dn = 1'b0;
    sense = 1'b0;
    wt = 32'h0000_0000;
    ctype = sdd_pkg::SDD_CLK_STEP_DIR;

    // Pins in order: step, direction, enable
    nxt_st.sync1 = {en_i, dir_i, step_i};
    nxt_st.sync2 = st_ff.sync1;

    // Filter length in sample periods, held inside the supported span
    need = clock_input_filter_setting;
    if (need < sdd_pkg::FILT_MIN_CYC) begin // see R12
      need = sdd_pkg::FILT_MIN_CYC;
    end
    if (need > sdd_pkg::FILT_MAX_CYC) begin // see R12
      need = sdd_pkg::FILT_MAX_CYC;
    end

    for (int i = 0; i < 2; i++) begin
      if (st_ff.sync2[i] != st_ff.filt[i]) begin
        if (st_ff.fcnt[i] >= 9'(need - 9'h001)) begin // see R18
          nxt_st.filt[i] = st_ff.sync2[i];
          nxt_st.fcnt[i] = 9'h000;
        end else begin
          nxt_st.fcnt[i] = 9'(st_ff.fcnt[i] + 9'h001);
        end
      end else begin
        nxt_st.fcnt[i] = 9'h000;
      end
    end
    nxt_st.filt_prev = st_ff.filt;

    quad_phase_a = st_ff.filt[0];
    quad_phase_b = st_ff.filt[1];
    a_chg = quad_phase_a ^ st_ff.filt_prev[0];
    b_chg = quad_phase_b ^ st_ff.filt_prev[1];
    step_rise = quad_phase_a & ~st_ff.filt_prev[0];
    dir_rise = quad_phase_b & ~st_ff.filt_prev[1];

    // Direction and resolution are latched only on a rising step edge
    if (step_rise) begin // see R9 R10
      nxt_st.dir_lat = quad_phase_b;
      nxt_st.res_lat = res_weight;
    end

    if (clk_type == 2'h1) begin
      ctype = sdd_pkg::SDD_CLK_QUAD;
    end else if (clk_type == 2'h3) begin
      ctype = sdd_pkg::SDD_CLK_UP_DOWN;
    end else begin
      ctype = sdd_pkg::SDD_CLK_STEP_DIR; // see R3
    end

    unique case (ctype)
      sdd_pkg::SDD_CLK_STEP_DIR: begin
        wt = {23'h000000, res_weight}; // see R5 R9
        sense = quad_phase_b ^ dir_invert; // see R6
        mv_up = step_rise & sense; // see R4
        mv_dn = step_rise & ~sense; // see R4
      end
      sdd_pkg::SDD_CLK_QUAD: begin
        wt = {23'h000000, res_weight}; // see R5
        // One channel edge per move; a double transition is dropped
        if (a_chg ^ b_chg) begin // see R7 R17
          sense = (quad_phase_a ^ st_ff.filt_prev[1]) ^ dir_invert;
          mv_up = sense;
          mv_dn = ~sense;
        end
      end
      sdd_pkg::SDD_CLK_UP_DOWN: begin
        wt = {23'h000000, res_weight}; // see R5
        // Coincident up and down edges cancel
        if (step_rise ^ dir_rise) begin // see R7 R8
          mv_up = step_rise ^ dir_invert;
          mv_dn = ~(step_rise ^ dir_invert);
        end
      end
    endcase

    // Counter runs whether or not the stage is enabled
    if (mv_up) begin // see R2
      nxt_st.pos = 32'(st_ff.pos + wt);
    end else if (mv_dn) begin // see R2
      nxt_st.pos = 32'(st_ff.pos - wt);
    end
    nxt_st.moved = mv_up | mv_dn;

    // Open input is pulled high externally, so it enables
    nxt_st.stage_en = st_ff.sync2[2]; // see R1 R13

    nxt_st.run_cur = run_current; // see R11
    nxt_st.hold_cur = hold_current; // see R11

    // Serial side: select level, received-word toggle
    nxt_st.cs_s1 = spi_cs_n;
    nxt_st.cs_s2 = st_ff.cs_s1;
    nxt_st.miso_oe = ~st_ff.cs_s2; // see R15 R16
    nxt_st.tgl_s1 = kp_ff.tgl;
    nxt_st.tgl_s2 = st_ff.tgl_s1;
    nxt_st.tgl_prev = st_ff.tgl_s2;
    nxt_st.cfg_vld = st_ff.tgl_s2 ^ st_ff.tgl_prev;
    if (st_ff.tgl_s2 ^ st_ff.tgl_prev) begin
      nxt_st.cfg = kp_ff.rx;
    end
    // Snapshot is frozen while selected so the link reads a steady word
    if (st_ff.cs_s2) begin
      nxt_st.snap = st_ff.pos;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // Synchronisers reset to the filtered level, so release shows no false edge
      st_ff <= '{
        sync1: 3'h0, sync2: 3'h0, filt: 2'h0, filt_prev: 2'h0, fcnt: '0,
        stage_en: 1'b0, pos: sdd_pkg::POS_RST, moved: 1'b0, dir_lat: 1'b0,
        res_lat: sdd_pkg::RES_RST, run_cur: sdd_pkg::CUR_RST,
        hold_cur: sdd_pkg::CUR_RST, cs_s1: 1'b1, cs_s2: 1'b1, tgl_s1: 1'b0,
        tgl_s2: 1'b0, tgl_prev: 1'b0, cfg: sdd_pkg::WORD_RST, cfg_vld: 1'b0,
        miso_oe: 1'b0, snap: sdd_pkg::POS_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Link domain: frame state ends with the select line
  assign frame_rst_n = nrst & ~spi_cs_n;

  always_comb begin
    nxt_fr = fr_ff;
    nxt_kp = kp_ff;
    // One bit per serial clock cycle
    nxt_fr.shift = {fr_ff.shift[29:0], spi_mosi}; // see R14
    nxt_fr.miso = st_ff.snap[5'(sdd_pkg::SPI_LAST_BIT - fr_ff.cnt)]; // see R14
    nxt_fr.cnt = 5'(fr_ff.cnt + 5'h01);
    if (fr_ff.cnt == sdd_pkg::SPI_LAST_BIT) begin
      nxt_kp.rx = {fr_ff.shift, spi_mosi};
      nxt_kp.tgl = ~kp_ff.tgl;
    end
  end

  always_ff @(posedge spi_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr_ff <= '{cnt: 5'h00, shift: 31'h0000_0000, miso: 1'b0};
    end else begin
      fr_ff <= nxt_fr;
    end
  end

  always_ff @(posedge spi_clk or negedge nrst) begin
    if (!nrst) begin
      kp_ff <= '{rx: sdd_pkg::WORD_RST, tgl: 1'b0};
    end else begin
      kp_ff <= nxt_kp;
    end
  end

  assign stage_enable     = st_ff.stage_en;
  assign position         = st_ff.pos;
  assign step_moved       = st_ff.moved;
  assign dir_latched      = st_ff.dir_lat;
  assign res_latched      = st_ff.res_lat;
  assign run_current_out  = st_ff.run_cur;
  assign hold_current_out = st_ff.hold_cur;
  assign cfg_word         = st_ff.cfg;
  assign cfg_word_valid   = st_ff.cfg_vld;
  assign spi_miso_o       = fr_ff.miso;
  assign spi_miso_oe      = st_ff.miso_oe;

endmodule // sdd_step_dir_decoder
`default_nettype wire

// ==== sdd_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdd_props (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        step_i,
  input wire logic        dir_i,
  input wire logic        en_i,
  input wire logic [1:0]  clk_type,
  input wire logic        dir_invert,
  input wire logic [8:0]  clock_input_filter_setting,
  input wire logic [6:0]  run_current,
  input wire logic        spi_cs_n,
  input wire logic        stage_enable,
  input wire logic [31:0] position,
  input wire logic        step_moved,
  input wire logic        dir_latched,
  input wire logic [8:0]  res_latched,
  input wire logic [6:0]  run_current_out,
  input wire logic        spi_miso_oe
);
  logic [31:0] w32;
  assign w32 = {23'h0, res_latched};
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_stage_follows_en: assert property ($stable(en_i) [*5] |-> stage_enable == en_i)
    else $error("stage enable off pin");
  a_move_flagged: assert property (position != $past(position) |-> step_moved)
    else $error("unflagged move");
  a_pulse_single: assert property (step_moved |=> !step_moved)
    else $error("move pulse too long");
  a_quiet_no_move:
    assert property (($stable(step_i) && $stable(dir_i) && clock_input_filter_setting < 9'h004)
      [*8] |-> !step_moved) else $error("move without pin edge");
  a_step_delta: assert property (step_moved && clk_type == 2'h0 |->
    position == $past(position) + ((dir_latched ^ dir_invert) ? w32 : -w32))
    else $error("wrong step size or sign");
  a_latch_hold:
    assert property (clk_type == 2'h0 && !step_moved |-> $stable(dir_latched) &&
      $stable(res_latched)) else $error("latch moved off step");
  a_cur_direct: assert property ($stable(run_current) [*2] |-> run_current_out == run_current)
    else $error("run current lags");
  a_oe_select: assert property ($stable(spi_cs_n) [*5] |-> spi_miso_oe == !spi_cs_n)
    else $error("miso enable wrong");
endmodule // sdd_props
bind sdd_step_dir_decoder sdd_props u_sdd_props (.mclk, .nrst, .step_i, .dir_i, .en_i,
  .clk_type, .dir_invert, .clock_input_filter_setting, .run_current, .spi_cs_n, .stage_enable,
  .position, .step_moved, .dir_latched, .res_latched, .run_current_out, .spi_miso_oe);
`default_nettype wire

// ==== sdd_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdd_ctrl_model (
  input  wire logic mclk,
  input  wire logic miso,
  output var logic  step_i,
  output var logic  dir_i,
  output var logic  spi_clk,
  output var logic  spi_cs_n,
  output var logic  spi_mosi
);
  initial {step_i, dir_i, spi_clk, spi_cs_n, spi_mosi} = 5'h02;
  // Both pins change at one falling edge, then hold for n cycles
  task pins(input logic a, input logic b, input int n);
    @(negedge mclk);
    step_i = a;
    dir_i = b;
    repeat (n) @(negedge mclk);
  endtask
  task frame(input logic [31:0] tx, output logic [31:0] rx);
    @(negedge mclk);
    spi_cs_n = 1'h0;
    repeat (4) @(negedge mclk);
    for (int k = 31; k >= 0; k--) begin
      #3 spi_mosi = tx[k];
      #3 spi_clk = 1'h1;
      #6 spi_clk = 1'h0;
      rx[k] = miso;
    end
    repeat (8) @(negedge mclk);
    spi_cs_n = 1'h1;
    spi_mosi = ~spi_mosi;
  endtask
endmodule // sdd_ctrl_model
`default_nettype wire

// ==== test_step_dir_input_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_step_dir_input_decoder;
  logic        mclk = 1'h0;
  logic        nrst = 1'h0;
  logic        en_i = 1'h1;
  logic        inv = 1'h0;
  logic [1:0]  ct = 2'h0;
  logic [8:0]  w = 9'h001;
  logic [8:0]  filt = 9'h002;
  logic [6:0]  rc = 7'h00;
  logic [6:0]  hc = 7'h00;
  logic [31:0] exp_pos = 32'h0;
  logic [31:0] rx;
  logic [15:0] r;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          vld_count = 0;
  wire logic        step_i, dir_i, sck, cs_n, mosi, miso, miso_o, miso_oe;
  wire logic        stage_enable, dir_latched, cfg_vld;
  wire logic [31:0] position, cfg_word;
  wire logic [8:0]  res_latched;
  wire logic [6:0]  rco, hco;
  // Row: {clk type, invert, enable}, {step, dir, 2'h0}, weight, signed move
  logic [15:0] rows [14] = '{16'h1430, 16'h1c33, 16'h0030, 16'h083d, 16'hb050, 16'hb855,
    16'hd020, 16'hd42e, 16'hdc22, 16'h5040, 16'h5844, 16'h5c44, 16'h744c, 16'h5044};
  assign miso = miso_oe ? miso_o : 1'hz;
  always #20 mclk = ~mclk;
  // Word pulses are counted on the falling edge, where they are settled
  always @(negedge mclk) begin
    if (cfg_vld === 1'h1) begin
      vld_count++;
    end
  end
  sdd_step_dir_decoder u_sdd_step_dir_decoder (.mclk, .nrst, .step_i, .dir_i, .en_i,
    .clk_type(ct), .dir_invert(inv), .res_weight(w), .clock_input_filter_setting(filt),
    .run_current(rc), .hold_current(hc), .spi_clk(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .stage_enable, .position, .step_moved(), .dir_latched, .res_latched,
    .run_current_out(rco), .hold_current_out(hco), .cfg_word, .cfg_word_valid(cfg_vld),
    .spi_miso_o(miso_o), .spi_miso_oe(miso_oe));
  sdd_ctrl_model u_sdd_ctrl_model (.mclk, .miso, .step_i, .dir_i, .spi_clk(sck),
    .spi_cs_n(cs_n), .spi_mosi(mosi));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    chk("position", position, 32'h0);
    chk("res", 32'(res_latched), 32'h1);
    nrst = 1'h1;
    repeat (4) @(negedge mclk);
    foreach (rows[i]) begin
      r = rows[i];
      {ct, inv, en_i} = r[15:12];
      w = 9'(r[7:4]);
      u_sdd_ctrl_model.pins(r[11], r[10], 10);
      exp_pos += 32'(signed'(r[3:0]));
      chk("position", position, exp_pos);
      chk("stage", 32'(stage_enable), 32'(en_i));
    end
    ct = 2'h0;
    w = 9'h003;
    u_sdd_ctrl_model.pins(1'h0, 1'h1, 10);
    u_sdd_ctrl_model.pins(1'h1, 1'h1, 10);
    w = 9'h007;
    u_sdd_ctrl_model.pins(1'h1, 1'h0, 10);
    chk("dir", 32'(dir_latched), 32'h1);
    chk("res", 32'(res_latched), 32'h3);
    u_sdd_ctrl_model.pins(1'h0, 1'h0, 10);
    u_sdd_ctrl_model.pins(1'h1, 1'h0, 10);
    exp_pos += 32'h3 - 32'h7;
    chk("position", position, exp_pos);
    chk("dir", 32'(dir_latched), 32'h0);
    filt = 9'h00a;
    u_sdd_ctrl_model.pins(1'h0, 1'h0, 20);
    u_sdd_ctrl_model.pins(1'h1, 1'h0, 5);
    u_sdd_ctrl_model.pins(1'h0, 1'h0, 20);
    chk("position", position, exp_pos);
    u_sdd_ctrl_model.pins(1'h1, 1'h0, 20);
    exp_pos -= 32'h7;
    chk("position", position, exp_pos);
    filt = 9'h002;
    rc = 7'h2a;
    hc = 7'h15;
    repeat (2) @(negedge mclk);
    chk("run", 32'(rco), 32'h2a);
    chk("hold", 32'(hco), 32'h15);
    u_sdd_ctrl_model.frame(32'ha5c3_0f96, rx);
    chk("snapshot", rx, exp_pos);
    chk("cfg", cfg_word, 32'ha5c3_0f96);
    chk("valid", 32'(vld_count), 32'h1);
    // Second reset in mid-run: state returns to its reset values
    nrst = 1'h0;
    repeat (2) @(negedge mclk);
    chk("position", position, 32'h0);
    chk("res", 32'(res_latched), 32'h1);
    chk("cfg", cfg_word, 32'h0);
    chk("stage", 32'(stage_enable), 32'h0);
    nrst = 1'h1;
    repeat (4) @(negedge mclk);
    chk("stage", 32'(stage_enable), 32'(en_i));
    tally_and_finish;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    tally_and_finish;
  end
endmodule // test_step_dir_input_decoder
`default_nettype wire
